// ---- design/reset_source_defines.svh ----
// constants of the reset source controller: offsets, bits, resets, timing
// assumes it is included by bare name wherever a constant is needed
`ifndef RESET_SOURCE_DEFINES_SVH
`define RESET_SOURCE_DEFINES_SVH

// ======================================================================
// register offsets (byte addresses, one word each)
`define RESET_SOURCE_REG_OFS        12'h000
`define ENABLE_VIEW_OFS   12'h004
`define SUPPLY_CTRL_OFS   12'h008
`define WDT_CTRL_OFS      12'h00C
`define WDT_SERVICE_OFS   12'h010

// ======================================================================
// field positions
`define BIT_USB           7
`define BIT_FLASH         6
`define BIT_COMP          5
`define BIT_SW            4
`define BIT_WDT           3
`define BIT_MCD           2
`define BIT_POR           1
`define BIT_PIN           0
`define SUPPLY_EN_BIT     7
`define SUPPLY_STAT_BIT   6
`define WDT_EN_BIT        0
`define WDT_LIMIT_LSB     16

// ======================================================================
// reset values
`define FLAGS_POR_RST     8'h02
`define SUPPLY_EN_RST     1'b1
`define WDT_EN_RST        1'b1
`define WDT_LIMIT_RST     16'hFFFF
`define SYNC_IDLE_RST     5'h19

// ======================================================================
// timing and limits
`define PCLK_FREQ_MHZ     100
`define RESET_DELAY_NS    5000
`define RESET_DELAY_CYC   ((`RESET_DELAY_NS * `PCLK_FREQ_MHZ + 999) / 1000)
`define MCD_TIMEOUT_US    100
`define WDT_PRESCALE      12
`define USER_CODE_TOP     16'h3DFF

`endif

// ---- design/reset_source_pkg.sv ----
// types shared by the reset source controller
// assumes nothing beyond a SystemVerilog compiler
package reset_source_pkg;

  // ====================================================================
  // reset sequence states, gray along run -> hold -> release
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_HOLD    = 2'b01,
    ST_RELEASE = 2'b11
  } seq_state_t;

  // ====================================================================
  // one bit per reset cause, in reset source register order
  typedef struct packed {
    logic usb;
    logic flash;
    logic comp;
    logic sw;
    logic wdt;
    logic missing_clock_detector;
    logic por;
    logic pin;
  } reset_cause_t;

  // ====================================================================
  // flash-side accesses reported by the core, one cycle each
  typedef struct packed {
    logic        program_store_write_enable;
    logic        move_wr;
    logic [15:0] move_addr;
    logic        code_rd;
    logic [15:0] code_addr;
    logic        fetch;
    logic [15:0] fetch_addr;
    logic        secure_block;
  } flash_access_t;

endpackage

// ---- design/watchdog_counter.sv ----
// counter-array watchdog: prescaled up-counter with an expiry pulse
// assumes restart is held for the whole system reset
`timescale 1ns/1ps
`include "reset_source_defines.svh"

module watchdog_counter #(
  parameter int unsigned WIDTH    = 16,
  parameter int unsigned PRESCALE = `WDT_PRESCALE
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             restart,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] limit,
  // status
  output logic      [WIDTH-1:0] count,
  output logic                  expire
);

  localparam int unsigned PW = $clog2(PRESCALE);

  logic [PW-1:0]    prescale_reg;
  logic [WIDTH-1:0] count_reg;
  logic             expire_reg;
  logic             tick;

  assign tick   = (prescale_reg == PW'(PRESCALE - 1));
  assign count  = count_reg;
  assign expire = expire_reg;

  // ======================================================================
  // system clock divided down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= '0;
    end else if (restart || tick) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + PW'(1);
    end
  end

  // ======================================================================
  // count; a disabled watchdog holds its value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg  <= '0;
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= 1'b0;
      if (restart) begin
        count_reg <= '0;
      end else if (enable && tick) begin
        if (count_reg == limit) begin
          count_reg  <= '0;
          expire_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + WIDTH'(1);
        end
      end
    end
  end

endmodule

// ---- design/reset_source_controller.sv ----
// reset source controller: gathers reset requests, stretches the system
// reset, records the cause; assumes an APB master on pclk and an analog
// one-shot that raises clock_stall when pclk stops
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "reset_source_defines.svh"

module reset_source_controller
  import reset_source_pkg::*;
#(
  parameter int unsigned RELEASE_CYCLES = `RESET_DELAY_CYC,
  parameter int unsigned WDT_WIDTH      = 16
) (
  // apb slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // reset pin, open drain
  input  wire logic          rst_pin_n_in,
  output logic               rst_pin_out,
  output logic               rst_pin_oe,
  // system reset
  output logic               sys_reset_n,
  // missing clock detector
  input  wire logic          clock_stall,
  output logic               missing_clock_detector_en,
  // comparator and usb
  input  wire logic          comparator_out,
  input  wire logic          usb_bus_reset,
  input  wire logic          usb_function_enable,
  input  wire logic          vbus_level,
  input  wire logic          bus_supply_polarity,
  // supply monitor
  input  wire logic          supply_level_ok,
  output logic               supply_monitor_enable,
  // flash accesses from the core
  input  wire flash_access_t flash_access
);

  // ======================================================================
  // helpers
  function automatic logic above_user_space(input logic [15:0] addr);
    above_user_space = (addr > `USER_CODE_TOP);
  endfunction

  // ======================================================================
  // two-flop synchronisers for pin and foreign-clock inputs
  logic [4:0] async_in;
  logic [4:0] sync_meta_reg;
  logic [4:0] sync_reg;
  logic       pin_s;
  logic       comp_s;
  logic       usb_bus_s;
  logic       vbus_s;
  logic       supply_ok_s;

  assign async_in = {rst_pin_n_in, comparator_out, usb_bus_reset,
                     vbus_level, supply_level_ok};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta_reg <= `SYNC_IDLE_RST;
      sync_reg      <= `SYNC_IDLE_RST;
    end else begin
      sync_meta_reg <= async_in;
      sync_reg      <= sync_meta_reg;
    end
  end

  assign pin_s       = sync_reg[4];
  assign comp_s      = sync_reg[3];
  assign usb_bus_s   = sync_reg[2];
  assign vbus_s      = sync_reg[1];
  assign supply_ok_s = sync_reg[0];

  // ======================================================================
  // declarations
  seq_state_t             state_reg;
  seq_state_t             state_next;
  reset_cause_t           cause_acc_reg;
  reset_cause_t           acc_next;
  reset_cause_t           flags_reg;
  reset_cause_t           req;
  logic [15:0]            release_cnt_reg;
  logic [15:0]            cnt_next;
  logic                   sys_run;
  logic                   pin_drive_reg;
  logic [1:0]             drive_tail_reg;
  logic                   pin_masked;
  logic                   mcd_hit_reg;
  logic                   mcd_trip;
  logic                   usb_en_reg;
  logic                   comp_en_reg;
  logic                   mcd_en_reg;
  logic                   supply_sel_reg;
  logic                   supply_en_reg;
  logic                   sw_force_reg;
  logic                   por_force_reg;
  logic                   wdt_en_reg;
  logic [WDT_WIDTH-1:0]   wdt_limit_reg;
  logic [WDT_WIDTH-1:0]   wdt_count;
  logic                   wdt_expire;
  logic                   flash_err;
  logic                   apb_write;
  logic                   mapped;
  logic                   rsrc_write;
  logic [31:0]            read_mux;
  logic [31:0]            prdata_reg;

  assign sys_run = (state_reg == ST_RUN);

  // ======================================================================
  // reset requests
  assign flash_err =
    (flash_access.program_store_write_enable && flash_access.move_wr &&
     above_user_space(flash_access.move_addr)) ||
    (flash_access.code_rd &&
     above_user_space(flash_access.code_addr)) ||
    (flash_access.fetch &&
     above_user_space(flash_access.fetch_addr)) ||
    flash_access.secure_block;

  always_comb begin
    req       = '0;
    // our own pin drive must not read back as an external reset
    req.pin   = !pin_s && !pin_masked;
    req.missing_clock_detector   = mcd_hit_reg;
    req.comp  = comp_en_reg && !comp_s;
    req.wdt   = wdt_expire;
    req.flash = flash_err;
    req.sw    = sw_force_reg;
    req.usb   = usb_en_reg &&
                ((usb_bus_s && usb_function_enable) ||
                 (vbus_s == bus_supply_polarity));
    req.por   = por_force_reg ||
                (supply_sel_reg && supply_en_reg && !supply_ok_s);
  end

  // ======================================================================
  // reset sequence: hold while any request stands, then stretch
  always_comb begin
    state_next = state_reg;
    acc_next   = cause_acc_reg;
    cnt_next   = release_cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (|req) begin
          state_next = ST_HOLD;
          acc_next   = req;
        end
      end
      ST_HOLD: begin
        acc_next = reset_cause_t'(cause_acc_reg | req);
        if (!(|req)) begin
          state_next = ST_RELEASE;
          cnt_next   = '0;
        end
      end
      ST_RELEASE: begin
        if (|req) begin
          state_next = ST_HOLD;
          acc_next   = reset_cause_t'(cause_acc_reg | req);
        end else if (release_cnt_reg == 16'(RELEASE_CYCLES - 1)) begin
          state_next = ST_RUN;
        end else begin
          cnt_next = release_cnt_reg + 16'h0001;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  // power-on enters the stretch as a power-on cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= ST_RELEASE;
      cause_acc_reg   <= reset_cause_t'(`FLAGS_POR_RST);
      release_cnt_reg <= '0;
    end else begin
      state_reg       <= state_next;
      cause_acc_reg   <= acc_next;
      release_cnt_reg <= cnt_next;
    end
  end

  // flags take the causes on leaving reset; por stays 0 unless caused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= reset_cause_t'(`FLAGS_POR_RST);
    end else if (state_reg == ST_RELEASE && state_next == ST_RUN) begin
      flags_reg <= cause_acc_reg;
    end
  end

  // only power-on, software-forced power-on and supply resets pull the pin low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_drive_reg <= 1'b1;
    end else begin
      pin_drive_reg <= (state_next != ST_RUN) && acc_next.por;
    end
  end

  // the pin synchroniser lags our release by two edges; keep masking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_tail_reg <= 2'h3;
    end else begin
      drive_tail_reg <= {drive_tail_reg[0], pin_drive_reg};
    end
  end

  assign pin_masked = pin_drive_reg || (|drive_tail_reg);

  // ======================================================================
  // missing clock: set without a clock edge, since pclk may be dead
  assign mcd_trip = clock_stall && mcd_en_reg;

  always_ff @(posedge pclk or negedge presetn or posedge mcd_trip) begin
    if (!presetn) begin
      mcd_hit_reg <= 1'b0;
    end else if (mcd_trip) begin
      mcd_hit_reg <= 1'b1;
    end else if (state_reg == ST_HOLD && cause_acc_reg.missing_clock_detector) begin
      mcd_hit_reg <= 1'b0;
    end
  end

  // ======================================================================
  // apb slave, zero wait states
  assign apb_write  = psel && penable && pwrite && sys_run;
  assign rsrc_write = apb_write && (paddr == `RESET_SOURCE_REG_OFS);

  always_comb begin
    mapped   = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      `RESET_SOURCE_REG_OFS: begin
        read_mux[7:0] = flags_reg;
      end
      `ENABLE_VIEW_OFS: begin
        read_mux[`BIT_USB]  = usb_en_reg;
        read_mux[`BIT_COMP] = comp_en_reg;
        read_mux[`BIT_MCD]  = mcd_en_reg;
        read_mux[`BIT_POR]  = supply_sel_reg;
      end
      `SUPPLY_CTRL_OFS: begin
        read_mux[`SUPPLY_EN_BIT]   = supply_en_reg;
        read_mux[`SUPPLY_STAT_BIT] = supply_ok_s;
      end
      `WDT_CTRL_OFS: begin
        read_mux[`WDT_EN_BIT] = wdt_en_reg;
        read_mux[`WDT_LIMIT_LSB +: WDT_WIDTH] = wdt_limit_reg;
      end
      `WDT_SERVICE_OFS: begin
        read_mux[WDT_WIDTH-1:0] = wdt_count;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // read data captured in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= read_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ======================================================================
  // source enables; writes land in enables, reads show flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_en_reg     <= 1'b0;
      comp_en_reg    <= 1'b0;
      mcd_en_reg     <= 1'b0;
      supply_sel_reg <= 1'b0;
      sw_force_reg   <= 1'b0;
      por_force_reg  <= 1'b0;
    end else begin
      sw_force_reg  <= rsrc_write && pwdata[`BIT_SW];
      por_force_reg <= rsrc_write && pwdata[`BIT_PIN];
      if (!sys_run) begin
        usb_en_reg  <= 1'b0;
        comp_en_reg <= 1'b0;
        mcd_en_reg  <= 1'b0;
      end else if (rsrc_write) begin
        usb_en_reg     <= pwdata[`BIT_USB];
        comp_en_reg    <= pwdata[`BIT_COMP];
        mcd_en_reg     <= pwdata[`BIT_MCD];
        supply_sel_reg <= pwdata[`BIT_POR];
      end
    end
  end

  assign missing_clock_detector_en = mcd_en_reg;

  // supply monitor enable survives every reset but power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_en_reg <= `SUPPLY_EN_RST;
    end else if (apb_write && paddr == `SUPPLY_CTRL_OFS) begin
      supply_en_reg <= pwdata[`SUPPLY_EN_BIT];
    end
  end

  assign supply_monitor_enable = supply_en_reg;

  // ======================================================================
  // watchdog control, back to enabled on every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_en_reg    <= `WDT_EN_RST;
      wdt_limit_reg <= `WDT_LIMIT_RST;
    end else if (!sys_run) begin
      wdt_en_reg    <= `WDT_EN_RST;
      wdt_limit_reg <= `WDT_LIMIT_RST;
    end else if (apb_write && paddr == `WDT_CTRL_OFS) begin
      wdt_en_reg    <= pwdata[`WDT_EN_BIT];
      wdt_limit_reg <= pwdata[`WDT_LIMIT_LSB +: WDT_WIDTH];
    end
  end

  watchdog_counter #(
    .WIDTH    (WDT_WIDTH),
    .PRESCALE (`WDT_PRESCALE)
  ) i_watchdog_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (!sys_run ||
              (apb_write && paddr == `WDT_SERVICE_OFS)),
    .enable  (wdt_en_reg),
    .limit   (wdt_limit_reg),
    .count   (wdt_count),
    .expire  (wdt_expire)
  );

  // ======================================================================
  // pins and system reset
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = pin_drive_reg;
  assign sys_reset_n = sys_run && !mcd_hit_reg;

  // ======================================================================
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rsrc_write_bit(int b);
    psel && penable && pwrite && sys_run &&
    paddr == `RESET_SOURCE_REG_OFS && pwdata[b];
  endsequence

  sequence s_leave_reset;
    state_reg == ST_RELEASE ##1 state_reg == ST_RUN;
  endsequence

  a_pin_enters_reset: assert property (
    sys_run && !pin_s && !pin_masked |=> !sys_reset_n && cause_acc_reg.pin)
    else $error("pin low did not start a reset");

  a_flags_on_exit: assert property (
    s_leave_reset |-> flags_reg == $past(cause_acc_reg))
    else $error("flags differ from causes after release");

  a_mcd_resets: assert property (
    mcd_hit_reg && sys_run |=> !sys_reset_n && cause_acc_reg.missing_clock_detector)
    else $error("missing clock did not reset");

  a_mcd_enable_wr: assert property (
    s_rsrc_write_bit(`BIT_MCD) |=> missing_clock_detector_en)
    else $error("detector not enabled by write");

  a_pin_untouched: assert property (
    rst_pin_oe |-> cause_acc_reg.por && !sys_run)
    else $error("pin driven by an internal reset");

  a_comp_resets: assert property (
    sys_run && comp_en_reg && !comp_s |=> !sys_run && cause_acc_reg.comp)
    else $error("comparator low did not reset");

  a_wdt_after_reset: assert property (
    s_leave_reset |-> wdt_en_reg && wdt_limit_reg == `WDT_LIMIT_RST)
    else $error("watchdog not enabled after reset");

  a_wdt_resets: assert property (
    sys_run && wdt_expire |=> !sys_run && cause_acc_reg.wdt)
    else $error("watchdog expiry did not reset");

  a_flash_resets: assert property (
    sys_run && flash_err |=> !sys_run && cause_acc_reg.flash)
    else $error("flash error did not reset");

  a_sw_force: assert property (
    s_rsrc_write_bit(`BIT_SW) |-> ##2 !sys_run && cause_acc_reg.sw)
    else $error("software write did not reset");

  a_usb_resets: assert property (
    sys_run && req.usb |=> !sys_run && cause_acc_reg.usb)
    else $error("usb request did not reset");

  a_por_cleared: assert property (
    s_leave_reset ##0 !$past(cause_acc_reg.por) |-> !flags_reg.por)
    else $error("power-on flag left set");

endmodule

// ---- tb/reset_agent.sv ----
// far side of the reset pin: external agent plus board pull-up
// assumes the design pulls the pin only through rst_pin_oe
`timescale 1ns/1ps
module reset_agent (
  // design side
  input  wire logic pin_oe,
  input  wire logic pin_out,
  // external agent
  input  wire logic ext_low,
  output logic      pin_n
);
  // ==========
  // wired-and; a released pin floats high through the pull-up
  assign pin_n = ~((pin_oe & ~pin_out) | ext_low);
endmodule

// ---- tb/reset_source_controller_tb.sv ----
// testbench of the reset source controller, one task per group of scenarios
// assumes the design files and reset_agent are compiled first
`timescale 1ns/1ps
`include "reset_source_defines.svh"
module reset_source_controller_tb
  import reset_source_pkg::*;
;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic          rst_pin_n_in, rst_pin_out, rst_pin_oe, sys_reset_n;
  logic          clock_stall, missing_clock_detector_en, comparator_out;
  logic          usb_bus_reset, usb_function_enable, vbus_level;
  logic          bus_supply_polarity, supply_level_ok, supply_monitor_enable;
  logic          ext_low;
  flash_access_t flash_access;
  int            miscompares, checked;

  // ==========
  // short stretch keeps every reset scenario brief
  reset_source_controller #(.RELEASE_CYCLES(6)) i_reset_source_controller (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rst_pin_n_in, .rst_pin_out, .rst_pin_oe,
    .sys_reset_n, .clock_stall, .missing_clock_detector_en,
    .comparator_out, .usb_bus_reset, .usb_function_enable, .vbus_level,
    .bus_supply_polarity, .supply_level_ok, .supply_monitor_enable,
    .flash_access);
  reset_agent i_reset_agent (.pin_oe(rst_pin_oe), .pin_out(rst_pin_out),
    .ext_low, .pin_n(rst_pin_n_in));

  always #5 pclk = ~pclk;

  // ==========
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state limit here; the watchdog process ends a hung bus
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(string nm, logic [11:0] a, logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, q, exp);
  endtask

  task automatic idle();
    ext_low <= 1'b0;
    comparator_out <= 1'b1;
    usb_bus_reset <= 1'b0;
    vbus_level <= ~bus_supply_polarity;
    clock_stall <= 1'b0;
    supply_level_ok <= 1'b1;
    flash_access <= '0;
  endtask

  // waits for release; a pin pull during an internal reset is a fault
  task automatic wait_up(output logic oe);
    int n;
    n = 0;
    oe = 1'b0;
    while (sys_reset_n !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
      oe = oe | rst_pin_oe;
    end
    check("released", sys_reset_n, 1'b1);
  endtask

  task automatic wait_reset(logic [31:0] exp, bit internal);
    int   n;
    logic oe;
    n = 0;
    while (sys_reset_n !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check("entered", sys_reset_n, 1'b0);
    idle();
    wait_up(oe);
    if (internal) check("pin_pulled", oe, 1'b0);
    rd_chk("flags", `RESET_SOURCE_REG_OFS, exp);
  endtask

  // ==========
  task automatic t_por();
    logic [31:0] q;
    logic        e;
    wait_up(e);
    rd_chk("por_flags", `RESET_SOURCE_REG_OFS, 32'h02);
    rd_chk("wdt_ctrl", `WDT_CTRL_OFS, 32'hFFFF_0001);
    rd_chk("supply", `SUPPLY_CTRL_OFS, 32'hC0);
    check("supply_en", supply_monitor_enable, 1'b1);
    apb(1'b0, 12'h020, 32'h0, q, e);
    check("unmapped", e, 1'b1);
    $display("power-on test done");
  endtask

  task automatic t_sw_pin();
    wr(`RESET_SOURCE_REG_OFS, 32'h10);
    wait_reset(32'h10, 1'b1);
    ext_low <= 1'b1;
    wait_reset(32'h01, 1'b0);
    // forced power-on type reset, then a supply drop while selected
    wr(`RESET_SOURCE_REG_OFS, 32'h01);
    wait_reset(32'h02, 1'b0);
    wr(`RESET_SOURCE_REG_OFS, 32'h02);
    supply_level_ok <= 1'b0;
    wait_reset(32'h02, 1'b0);
    $display("software and pin test done");
  endtask

  task automatic t_mcd();
    wr(`RESET_SOURCE_REG_OFS, 32'h04);
    @(posedge pclk);
    check("mcd_on", missing_clock_detector_en, 1'b1);
    wr(`RESET_SOURCE_REG_OFS, 32'h00);
    @(posedge pclk);
    check("mcd_off", missing_clock_detector_en, 1'b0);
    wr(`RESET_SOURCE_REG_OFS, 32'h04);
    clock_stall <= 1'b1;
    wait_reset(32'h04, 1'b1);
    $display("missing clock test done");
  endtask

  task automatic t_comp_wdt();
    // comparator output is already settled high before enabling
    wr(`RESET_SOURCE_REG_OFS, 32'h20);
    rd_chk("enables", `ENABLE_VIEW_OFS, 32'h20);
    comparator_out <= 1'b0;
    wait_reset(32'h20, 1'b1);
    wr(`WDT_CTRL_OFS, 32'h0003_0001);
    // each service restarts the count well before the limit of 3 ticks
    repeat (3) begin
      wr(`WDT_SERVICE_OFS, 32'h0);
      repeat (28) @(posedge pclk);
      check("serviced", sys_reset_n, 1'b1);
    end
    // 29 clocks after a service the count steps of 12 clocks give 2
    rd_chk("wdt_count", `WDT_SERVICE_OFS, 32'h2);
    wait_reset(32'h08, 1'b1);
    $display("comparator and watchdog test done");
  endtask

  task automatic t_flash_usb();
    flash_access_t fa;
    fa = '0;
    fa.code_rd = 1'b1;
    fa.code_addr = `USER_CODE_TOP;
    flash_access <= fa;
    @(posedge pclk);
    flash_access <= '0;
    repeat (8) @(posedge pclk);
    check("edge_addr", sys_reset_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      fa = '0;
      fa.program_store_write_enable = (i == 0);
      fa.move_wr = (i == 0);
      fa.code_rd = (i == 1);
      fa.fetch = (i == 2);
      fa.secure_block = (i == 3);
      fa.move_addr = 16'h3E00;
      fa.code_addr = 16'h3E00;
      fa.fetch_addr = 16'h3E00;
      flash_access <= fa;
      @(posedge pclk);
      flash_access <= '0;
      wait_reset(32'h40, 1'b1);
    end
    for (int j = 0; j < 2; j++) begin
      wr(`RESET_SOURCE_REG_OFS, 32'h80);
      if (j == 0) begin
        usb_bus_reset <= 1'b1;
      end else begin
        vbus_level <= bus_supply_polarity;
      end
      wait_reset(32'h80, 1'b1);
    end
    $display("flash and usb test done");
  endtask

  // ==========
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    usb_function_enable = 1'b1;
    bus_supply_polarity = 1'b1;
    supply_level_ok = 1'b1;
    ext_low = 1'b0;
    comparator_out = 1'b1;
    usb_bus_reset = 1'b0;
    vbus_level = 1'b0;
    clock_stall = 1'b0;
    flash_access = '0;
    miscompares = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_sw_pin();
    t_mcd();
    t_comp_wdt();
    t_flash_usb();
    final_report();
  end

  // the scenarios need well under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
